// *** tmr_framer.sv ***
// Task management response framer: target-side builder and initiator-side decoder.
`timescale 1ns/1ps
module tmr_framer
  import tmr_pkg::*;
#(
  parameter logic [1:0]  DPS_RESPONSE = TMR_DPS_RESPONSE,
  parameter logic [15:0] RESP_LEN     = TMR_RESP_LEN
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                task_rcvd,
  input  wire logic                rsp_req_valid,
  input  wire tmr_pkg::tmr_req_t    rsp_req,
  output logic                     rsp_req_ready,
  output logic                     tx_valid,
  output tmr_pkg::tmr_frame_t       tx_frame,
  input  wire logic                tx_ready,
  output logic                     req_dropped,
  input  wire logic                rx_valid,
  input  wire tmr_pkg::tmr_frame_t  rx_frame,
  input  wire logic                nak_valid,
  input  wire tmr_pkg::tmr_task_t   task_hdr,
  output logic                     conf_valid,
  output tmr_pkg::tmr_conf_t        conf
);
  import tmr_pkg::*;

  typedef enum logic [1:0] {
    TMR_ST_IDLE,
    TMR_ST_SEND
  } tmr_state_t;

  tmr_state_t state_r;
  tmr_state_t state_nxt;
  logic [7:0] pend_r;
  logic [7:0] pend_nxt;
  tmr_frame_t frame_r;
  tmr_frame_t frame_nxt;
  logic       drop_r;
  logic       drop_nxt;
  logic [7:0] code_sel;
  logic       ready_r;
  logic       ready_nxt;
  logic       txv_r;
  logic       txv_nxt;
  logic       take_req;

  // Pick the response code for the requested service response.
  always_comb begin
    code_sel = TMR_RC_FAILED;
    case (rsp_req.srv)
      TMR_SR_COMPLETE:  code_sel = TMR_RC_COMPLETE;
      TMR_SR_SUCCEEDED: code_sel = TMR_RC_SUCCEEDED;
      TMR_SR_REJECTED:  code_sel = TMR_RC_NOT_SUPP;
      TMR_SR_BAD_LUN:   code_sel = TMR_RC_BAD_LUN;
      default: begin
        case (rsp_req.fail)
          TMR_FD_INVALID_FRAME: code_sel = TMR_RC_INVALID_FRM;
          TMR_FD_OVERLAP:       code_sel = TMR_RC_OVERLAP;
          default:              code_sel = TMR_RC_FAILED;
        endcase
      end
    endcase
  end

  // Builder state. A count of received TASK frames guards against responses
  // that have no request behind them; such a request is dropped and flagged.
  always_comb begin
    state_nxt = state_r;
    pend_nxt  = pend_r;
    frame_nxt = frame_r;
    drop_nxt  = 1'b0;
    take_req  = 1'b0;
    case (state_r)
      TMR_ST_IDLE: begin
        if (rsp_req_valid) begin
          if (pend_r == 8'h00 && !task_rcvd) begin
            drop_nxt = 1'b1;
          end else begin
            take_req = 1'b1;
            frame_nxt.dest_addr = rsp_req.nexus.init_addr;
            frame_nxt.src_addr  = rsp_req.nexus.tgt_addr;
            frame_nxt.lun       = rsp_req.nexus.lun;
            // The Q tag identifies the same task, so it takes precedence.
            frame_nxt.tag = rsp_req.nexus.has_q ? rsp_req.nexus.q_tag : rsp_req.assoc;
            frame_nxt.data_present_selector = DPS_RESPONSE;
            frame_nxt.resp_code = code_sel;
            frame_nxt.length    = RESP_LEN;
            state_nxt = TMR_ST_SEND;
          end
        end
      end
      TMR_ST_SEND: begin
        if (tx_ready) begin
          state_nxt = TMR_ST_IDLE;
        end
      end
      default: state_nxt = TMR_ST_IDLE;
    endcase
    // A notice and a take in one cycle cancel, so the count can never wrap
    // below zero; new notices saturate at the top of the count.
    if (task_rcvd && !take_req && pend_r != 8'hFF) begin
      pend_nxt = pend_r + 8'h01;
    end else if (take_req && !task_rcvd) begin
      pend_nxt = pend_r - 8'h01;
    end
    // Ready and valid are decoded from the next state, so both leave flip-flops directly.
    ready_nxt = (state_nxt == TMR_ST_IDLE);
    txv_nxt   = (state_nxt == TMR_ST_SEND);
  end

  // State registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= TMR_ST_IDLE;
      pend_r  <= 8'h00;
      frame_r <= '0;
      drop_r  <= 1'b0;
      ready_r <= 1'b1;
      txv_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r  <= pend_nxt;
      frame_r <= frame_nxt;
      drop_r  <= drop_nxt;
      ready_r <= ready_nxt;
      txv_r   <= txv_nxt;
    end
  end

  // Ready is registered state, so requests are taken only while idle.
  assign rsp_req_ready = ready_r;
  assign tx_valid      = txv_r;
  assign tx_frame      = frame_r;
  assign req_dropped   = drop_r;

  // Initiator-side decoder.
  tmr_decode #(
    .DPS_RESPONSE (DPS_RESPONSE),
    .RESP_LEN     (RESP_LEN)
  ) u_decode (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .rx_valid   (rx_valid),
    .rx_frame   (rx_frame),
    .nak_valid  (nak_valid),
    .task_hdr   (task_hdr),
    .conf_valid (conf_valid),
    .conf       (conf)
  );

endmodule // tmr_framer

// *** tmr_pkg.sv ***
// Package of types and constants for the task management response framer.
package tmr_pkg;

  // Field widths of the frame header and nexus.
  localparam int TMR_ADDR_W = 24;
  localparam int TMR_LUN_W  = 64;
  localparam int TMR_TAG_W  = 16;

  // Data-present selector encodings.
  localparam logic [1:0] TMR_DPS_NONE     = 2'h0;
  localparam logic [1:0] TMR_DPS_RESPONSE = 2'h1;
  localparam logic [1:0] TMR_DPS_SENSE    = 2'h2;

  // Response code encodings.
  localparam logic [7:0] TMR_RC_COMPLETE    = 8'h00;
  localparam logic [7:0] TMR_RC_INVALID_FRM = 8'h02;
  localparam logic [7:0] TMR_RC_NOT_SUPP    = 8'h04;
  localparam logic [7:0] TMR_RC_FAILED      = 8'h05;
  localparam logic [7:0] TMR_RC_SUCCEEDED   = 8'h08;
  localparam logic [7:0] TMR_RC_BAD_LUN     = 8'h09;
  localparam logic [7:0] TMR_RC_OVERLAP     = 8'h0A;

  // Expected length of a task management RESPONSE frame in bytes.
  localparam logic [15:0] TMR_RESP_LEN = 16'h001C;

  // Reset values of held outputs.
  localparam logic        TMR_VALID_RST = 1'b0;

  // Service responses exchanged with the task manager and application client.
  typedef enum logic [2:0] {
    TMR_SR_COMPLETE,
    TMR_SR_SUCCEEDED,
    TMR_SR_REJECTED,
    TMR_SR_BAD_LUN,
    TMR_SR_FAILURE
  } tmr_srv_t;

  // Failure detail chosen by the task manager for a failure response.
  typedef enum logic [1:0] {
    TMR_FD_INVALID_FRAME,
    TMR_FD_FUNC_FAILED,
    TMR_FD_OVERLAP
  } tmr_fail_t;

  // Nexus: initiator, target, logical unit and optional task tag.
  typedef struct packed {
    logic [TMR_ADDR_W-1:0] init_addr;
    logic [TMR_ADDR_W-1:0] tgt_addr;
    logic [TMR_LUN_W-1:0]  lun;
    logic                  has_q;
    logic [TMR_TAG_W-1:0]  q_tag;
  } tmr_nexus_t;

  // Response request from the task manager.
  typedef struct packed {
    tmr_nexus_t           nexus;
    tmr_srv_t             srv;
    tmr_fail_t            fail;
    logic [TMR_TAG_W-1:0] assoc;
  } tmr_req_t;

  // Header and payload fields of a RESPONSE frame.
  typedef struct packed {
    logic [TMR_ADDR_W-1:0] dest_addr;
    logic [TMR_ADDR_W-1:0] src_addr;
    logic [TMR_LUN_W-1:0]  lun;
    logic [TMR_TAG_W-1:0]  tag;
    logic [1:0]            data_present_selector;
    logic [7:0]            resp_code;
    logic [15:0]           length;
  } tmr_frame_t;

  // Header fields of the TASK frame that was sent.
  typedef struct packed {
    logic [TMR_LUN_W-1:0] lun;
    logic [TMR_TAG_W-1:0] tag;
    logic [TMR_TAG_W-1:0] managed_tag;
  } tmr_task_t;

  // Confirmation to the application client.
  typedef struct packed {
    tmr_srv_t             srv;
    logic [TMR_LUN_W-1:0] lun;
    logic [TMR_TAG_W-1:0] task_tag;
    logic [TMR_TAG_W-1:0] assoc;
  } tmr_conf_t;

endpackage

// *** tmr_decode.sv ***
// Decoder from a received RESPONSE frame to a registered service response.
`timescale 1ns/1ps
module tmr_decode
  import tmr_pkg::*;
#(
  parameter logic [1:0]  DPS_RESPONSE = TMR_DPS_RESPONSE,
  parameter logic [15:0] RESP_LEN     = TMR_RESP_LEN
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               rx_valid,
  input  wire tmr_pkg::tmr_frame_t rx_frame,
  input  wire logic               nak_valid,
  input  wire tmr_pkg::tmr_task_t  task_hdr,
  output logic                    conf_valid,
  output tmr_pkg::tmr_conf_t       conf
);
  import tmr_pkg::*;

  logic      conf_valid_r;
  logic      conf_valid_nxt;
  tmr_conf_t conf_r;
  tmr_conf_t conf_nxt;
  tmr_srv_t  srv_dec;

  // Map selector and code back to a service response; anything odd is a failure.
  always_comb begin
    srv_dec = TMR_SR_FAILURE;
    if (rx_frame.data_present_selector == DPS_RESPONSE &&
        rx_frame.length == RESP_LEN) begin
      case (rx_frame.resp_code)
        TMR_RC_COMPLETE:  srv_dec = TMR_SR_COMPLETE;
        TMR_RC_SUCCEEDED: srv_dec = TMR_SR_SUCCEEDED;
        TMR_RC_NOT_SUPP:  srv_dec = TMR_SR_REJECTED;
        TMR_RC_BAD_LUN:   srv_dec = TMR_SR_BAD_LUN;
        default:          srv_dec = TMR_SR_FAILURE;
      endcase
    end
  end

  // A NAK wins over a frame in the same cycle, since no RESPONSE may follow it.
  always_comb begin
    conf_valid_nxt = 1'b0;
    conf_nxt       = conf_r;
    if (nak_valid) begin
      conf_valid_nxt    = 1'b1;
      conf_nxt.srv      = TMR_SR_FAILURE;
      conf_nxt.lun      = task_hdr.lun;
      conf_nxt.task_tag = task_hdr.managed_tag;
      conf_nxt.assoc    = task_hdr.tag;
    end else if (rx_valid) begin
      conf_valid_nxt    = 1'b1;
      conf_nxt.srv      = srv_dec;
      conf_nxt.lun      = rx_frame.lun;
      conf_nxt.task_tag = rx_frame.tag;
      conf_nxt.assoc    = rx_frame.tag;
    end
  end

  // State registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conf_valid_r <= TMR_VALID_RST;
      conf_r       <= '0;
    end else begin
      conf_valid_r <= conf_valid_nxt;
      conf_r       <= conf_nxt;
    end
  end

  assign conf_valid = conf_valid_r;
  assign conf       = conf_r;

endmodule // tmr_decode

// *** tmr_framer_properties.sv ***
// Assertion checker for the task management response framer.
`timescale 1ns/1ps
module tmr_framer_properties
  import tmr_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                task_rcvd,
  input wire logic                rsp_req_valid,
  input wire tmr_pkg::tmr_req_t   rsp_req,
  input wire logic                rsp_req_ready,
  input wire logic                tx_valid,
  input wire tmr_pkg::tmr_frame_t tx_frame,
  input wire logic                tx_ready,
  input wire logic                rx_valid,
  input wire tmr_pkg::tmr_frame_t rx_frame,
  input wire logic                nak_valid,
  input wire tmr_pkg::tmr_task_t  task_hdr,
  input wire logic                conf_valid,
  input wire tmr_pkg::tmr_conf_t  conf
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A request taken alongside a TASK notice can never be refused.
  sequence s_take;
    rsp_req_valid && rsp_req_ready && task_rcvd;
  endsequence
  property p_dest;
    s_take |=> tx_valid && tx_frame.dest_addr == $past(rsp_req.nexus.init_addr);
  endproperty
  property p_lun;
    s_take |=> tx_frame.lun == $past(rsp_req.nexus.lun);
  endproperty
  property p_tag;
    s_take |=> tx_frame.tag == ($past(rsp_req.nexus.has_q) ? $past(rsp_req.nexus.q_tag)
                                                          : $past(rsp_req.assoc));
  endproperty
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame);
  endproperty
  property p_dps;
    tx_valid |-> tx_frame.data_present_selector == TMR_DPS_RESPONSE;
  endproperty
  property p_conf;
    rx_valid || nak_valid |=> conf_valid;
  endproperty
  property p_nak;
    nak_valid |=> conf.srv == TMR_SR_FAILURE && conf.lun == $past(task_hdr.lun);
  endproperty
  property p_ntag;
    nak_valid |=> conf.task_tag == $past(task_hdr.managed_tag) && conf.assoc == $past(task_hdr.tag);
  endproperty
  property p_assoc;
    rx_valid && !nak_valid |=> conf.assoc == $past(rx_frame.tag);
  endproperty
  a_dest: assert property (p_dest) else $error("bad destination");
  a_lun: assert property (p_lun) else $error("bad unit number");
  a_tag: assert property (p_tag) else $error("bad frame tag");
  a_hold: assert property (p_hold) else $error("frame changed while stalled");
  a_dps: assert property (p_dps) else $error("bad selector");
  a_conf: assert property (p_conf) else $error("no confirmation");
  a_nak: assert property (p_nak) else $error("bad negative answer");
  a_ntag: assert property (p_ntag) else $error("bad task tags");
  a_assoc: assert property (p_assoc) else $error("bad association");
endmodule // tmr_framer_properties
bind tmr_framer tmr_framer_properties i_tmr_framer_properties (.sys_clk, .rst, .task_rcvd,
  .rsp_req_valid, .rsp_req, .rsp_req_ready, .tx_valid, .tx_frame, .tx_ready, .rx_valid,
  .rx_frame, .nak_valid, .task_hdr, .conf_valid, .conf);

// *** tmr_remote_port.sv ***
// Model of the remote port that accepts outgoing frames with random stalls.
`timescale 1ns/1ps
module tmr_remote_port (
  input wire logic sys_clk,
  input wire logic rst,
  output logic     tx_ready
);
  int seed = 37852;
  // Stalls about one cycle in four, so both prompt and slow acceptance occur.
  always_ff @(posedge sys_clk) begin
    tx_ready <= rst ? 1'b0 : (($random(seed) & 3) != 0);
  end
endmodule // tmr_remote_port

// *** test_task_mgmt_response_framing.sv ***
// Self-checking testbench for the task management response framer.
`timescale 1ns/1ps
module test_task_mgmt_response_framing;
  import tmr_pkg::*;
  logic sys_clk = 0, rst = 1, task_rcvd = 0, rsp_req_valid = 0, rx_valid = 0, nak_valid = 0;
  logic rsp_req_ready, tx_valid, tx_ready, req_dropped, conf_valid;
  tmr_req_t   rsp_req = '0;
  tmr_frame_t tx_frame, rx_frame = '0;
  tmr_task_t  task_hdr = '0;
  tmr_conf_t  conf;
  int seed = 37852, n_mismatch = 0, cmp_count = 0, cyc = 0;
  localparam logic [7:0] RC [5] = '{TMR_RC_COMPLETE, TMR_RC_SUCCEEDED, TMR_RC_NOT_SUPP,
                                    TMR_RC_BAD_LUN, TMR_RC_FAILED};
  localparam logic [7:0] FC [3] = '{TMR_RC_INVALID_FRM, TMR_RC_FAILED, TMR_RC_OVERLAP};
  localparam logic [7:0] CODES [8] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A, 8'h33};
  tmr_framer i_tmr_framer (.sys_clk, .rst, .task_rcvd, .rsp_req_valid, .rsp_req, .rsp_req_ready,
    .tx_valid, .tx_frame, .tx_ready, .req_dropped, .rx_valid, .rx_frame, .nak_valid, .task_hdr,
    .conf_valid, .conf);
  tmr_remote_port i_tmr_remote_port (.sys_clk, .rst, .tx_ready);
  always #25 sys_clk = ~sys_clk;
  // A hang is cut short well beyond the seventy or so cycles the run needs.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk1(input logic a, input logic e);
    cmp_count++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR %0t flag %b expected %b", $time, a, e);
    end
  endtask
  task automatic chk_frame(input tmr_frame_t a, input tmr_frame_t e);
    cmp_count++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR %0t frame %h expected %h", $time, a, e);
    end
  endtask
  task automatic chk_conf(input tmr_conf_t a, input tmr_conf_t e);
    cmp_count++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR %0t confirmation %h expected %h", $time, a, e);
    end
  endtask
  function automatic tmr_srv_t exp_srv(input logic [7:0] c);
    case (c)
      TMR_RC_COMPLETE:  return TMR_SR_COMPLETE;
      TMR_RC_SUCCEEDED: return TMR_SR_SUCCEEDED;
      TMR_RC_NOT_SUPP:  return TMR_SR_REJECTED;
      TMR_RC_BAD_LUN:   return TMR_SR_BAD_LUN;
      default: return TMR_SR_FAILURE;
    endcase
  endfunction
  function automatic tmr_frame_t rf(input int k);
    tmr_frame_t f;
    f = {24'($random(seed)), 24'($random(seed)), $random(seed), $random(seed), 16'($random(seed)),
         (k == 8) ? TMR_DPS_SENSE : TMR_DPS_RESPONSE, CODES[k % 8], TMR_RESP_LEN};
    // A wrong length on an otherwise good completion, so only the length check can fail it.
    if (k == 9) begin
      f.length    = TMR_RESP_LEN + 16'h0001;
      f.resp_code = TMR_RC_COMPLETE;
    end
    return f;
  endfunction
  // Requests carry random addressing, with service and failure detail swept in full.
  // The notice tk rides with the request; ok says whether a frame must follow.
  task automatic do_req(input int s, input int fl, input logic tk, input logic ok);
    tmr_frame_t e;
    int n;
    n = 0;
    rsp_req = {24'($random(seed)), 24'($random(seed)), $random(seed), $random(seed), s[0],
               16'($random(seed)), tmr_srv_t'(s % 5), tmr_fail_t'(fl), 16'($random(seed))};
    e = {rsp_req.nexus.init_addr, rsp_req.nexus.tgt_addr, rsp_req.nexus.lun,
         s[0] ? rsp_req.nexus.q_tag : rsp_req.assoc, TMR_DPS_RESPONSE,
         (s % 5 == 4) ? FC[fl] : RC[s % 5], TMR_RESP_LEN};
    chk1(rsp_req_ready, 1'b1);
    rsp_req_valid = 1;
    task_rcvd = tk;
    tick;
    rsp_req_valid = 0;
    task_rcvd = 0;
    if (!ok) begin
      chk1(req_dropped, 1'b1);
      chk1(tx_valid, 1'b0);
      tick;
      return;
    end
    chk1(req_dropped, 1'b0);
    chk1(tx_valid, 1'b1);
    chk_frame(tx_frame, e);
    while (!(tx_valid && tx_ready) && n < 50) begin
      tick;
      n++;
    end
    chk1(tx_valid && tx_ready, 1'b1);
    tick;
  endtask
  // Valids are left high so that calls in a row arrive back to back.
  task automatic dec(input tmr_frame_t f, input logic nk);
    tmr_conf_t e;
    task_hdr = {$random(seed), $random(seed), 16'($random(seed)), 16'($random(seed))};
    rx_frame = f;
    rx_valid = 1;
    nak_valid = nk;
    e.srv = (nk || f.data_present_selector !== TMR_DPS_RESPONSE || f.length !== TMR_RESP_LEN)
            ? TMR_SR_FAILURE : exp_srv(f.resp_code);
    e.lun = nk ? task_hdr.lun : f.lun;
    e.task_tag = nk ? task_hdr.managed_tag : f.tag;
    e.assoc = nk ? task_hdr.tag : f.tag;
    tick;
    chk1(conf_valid, 1'b1);
    chk_conf(conf, e);
  endtask
  // Refusal first, then every service and failure detail, then decodes.
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rst = 0;
    do_req(0, 0, 1'b0, 1'b0);
    for (int i = 0; i < 15; i++) do_req(i, i / 5, 1'b1, 1'b1);
    // A notice banked ahead of its request is honoured once; then the bank is empty.
    task_rcvd = 1;
    tick;
    task_rcvd = 0;
    tick;
    do_req(5, 0, 1'b0, 1'b1);
    do_req(6, 0, 1'b0, 1'b0);
    for (int k = 0; k < 12; k++) dec(rf(k), k >= 10);
    rx_valid = 0;
    nak_valid = 0;
    tick;
    chk1(conf_valid, 1'b0);
    // Mid-run reset: outputs return to idle and a request follows at the first edge.
    rst = 1;
    tick;
    tick;
    rst = 0;
    chk1(tx_valid, 1'b0);
    chk_conf(conf, '0);
    do_req(7, 1, 1'b1, 1'b1);
    give_verdict;
  end
endmodule // test_task_mgmt_response_framing
